//--- rtl/psq_defs.svh
// Constants for the program sequencer and return stack.
// Functional notes
// - Fifteen-bit program counter addresses program memory.
// - Reset and interrupts load fixed vectors directly.
// - Vectors 0000h-0023h; code starts at 0024h.
// - Eight interrupt vectors in fixed priority order.
// - All four wake pins share one request.
// - Hold-release pins leave hold, no interrupt.
// - Stack is sixteen entries of 53 bits.
// - Call or interrupt pushes counter and context.
// - Plain return restores only the counter.
// - Masked return restores counter plus selected fields.
// - Stack wraps, overwrites oldest, never overflows.
// - Program memory is sixteen 2048-word pages.
// - Conditional branches stay inside current page.
// - Look-up table occupies 4000h to 7FFFh.
// - Element address from four pointer nibbles.
// - Table read returns addressed nibble.
// - Four-bit page register selects n times 0800h.
// - Far target is page bits over eleven bits.
`ifndef PSQ_DEFS_SVH
`define PSQ_DEFS_SVH

`define PSQ_PC_W         15
`define PSQ_PC_RESET     15'h0000
`define PSQ_VEC_FIRST    15'h0004
`define PSQ_VEC_LAST     15'h0020
`define PSQ_CODE_START   15'h0024
`define PSQ_PAGE_LSB     11
`define PSQ_PAGE_WORDS   2048
`define PSQ_TABLE_BASE   15'h4000
`define PSQ_STACK_DEPTH  16
`define PSQ_STACK_W      53
`define PSQ_NUM_IRQ      8
`define PSQ_IRQ_WAKE     2

`define PSQ_MASK_TAB     0
`define PSQ_MASK_BANK    1
`define PSQ_MASK_WRP     2
`define PSQ_MASK_ROMPG   3
`define PSQ_MASK_RAMPG   4
`define PSQ_MASK_ACC     5
`define PSQ_MASK_CARRY   6

`define PSQ_ADDR_PAGE    4'h0
`define PSQ_ADDR_TABLE_POINTER_NIBBLE_0    4'h1
`define PSQ_ADDR_TABLE_POINTER_NIBBLE_1    4'h2
`define PSQ_ADDR_TABLE_POINTER_NIBBLE_2    4'h3
`define PSQ_ADDR_TABLE_POINTER_NIBBLE_3    4'h4
`define PSQ_ADDR_DBKLO   4'h5
`define PSQ_ADDR_DBKHI   4'h6
`define PSQ_ADDR_WRP     4'h7
`define PSQ_ADDR_RAMPG   4'h8
`define PSQ_ADDR_PEND    4'h9
`define PSQ_ADDR_SP      4'hA
`define PSQ_ADDR_IRQEN   4'hB
`define PSQ_ADDR_PC      4'hC
`define PSQ_IRQEN_RESET  8'hFF

`endif

//--- rtl/psq_pkg.sv
// Types shared by the program sequencer files.
`default_nettype none
package psq_pkg;

   typedef enum logic [2:0] {
      CMD_NONE   = 3'b000,
      CMD_STEP   = 3'b001,
      CMD_JUMP   = 3'b010,
      CMD_CALL   = 3'b011,
      CMD_BRANCH = 3'b100,
      CMD_RET    = 3'b101,
      CMD_RETM   = 3'b110,
      CMD_TABLE  = 3'b111
   } psq_cmd_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_POP   = 2'b01,
      ST_TABLE = 2'b10
   } psq_state_e;

   typedef struct packed {
      psq_cmd_e    op;
      logic [10:0] target;
      logic [6:0]  mask;
   } psq_cmd_s;

   typedef struct packed {
      logic [15:0] tab;
      logic [3:0]  dbkLow;
      logic [1:0]  dbkHigh;
      logic [3:0]  work_reg_page;
      logic [3:0]  codePage;
      logic [2:0]  ramPage;
   } psq_regs_s;

   typedef struct packed {
      logic [14:0] pc;
      psq_regs_s   regs;
      logic [3:0]  acc;
      logic        carry;
   } psq_ctx_s;

endpackage
`default_nettype wire

//--- rtl/psq_sequencer.sv
// Program counter, interrupt vectoring, return stack, page and table addressing.
`default_nettype none
`include "psq_defs.svh"
module psq_sequencer (
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire logic               ce,
   input  wire logic [3:0]         regAddr,
   input  wire logic [15:0]        regWrData,
   input  wire logic               regWr,
   input  wire logic               regRd,
   output var  logic [15:0]        regRdData,
   input  wire psq_pkg::psq_cmd_s  cmd,
   input  wire logic [3:0]         accIn,
   input  wire logic               carryIn,
   input  wire logic               intEnable,
   input  wire logic               div0Irq,
   input  wire logic               timer0Irq,
   input  wire logic               div1Irq,
   input  wire logic               serialIrq,
   input  wire logic               timer1Irq,
   input  wire logic [3:0]         wakeIrqInputs_b,
   input  wire logic               extIrqLineA_b,
   input  wire logic               extIrqLineB_b,
   input  wire logic [3:0]         holdReleaseInputs_b,
   input  wire logic               holdActive,
   input  wire logic [15:0]        romData,
   output var  logic [14:0]        pc,
   output var  logic [14:0]        romAddr,
   output var  logic               busy,
   output var  psq_pkg::psq_regs_s regs,
   output var  logic [3:0]         accOut,
   output var  logic               accLoad,
   output var  logic               carryOut,
   output var  logic               carryLoad,
   output var  logic [3:0]         tableNibble,
   output var  logic               tableValid,
   output var  logic               intTaken,
   output var  logic               holdRelease
);
   // ---------------------------------------------
   // Pin synchronisers and edge detection
   // ---------------------------------------------
   logic [9:0] pinMeta;
   logic [9:0] pinSync;
   logic [5:0] pinPrev;
   logic [5:0] pinFall;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pinMeta <= 10'h3FF;
         pinSync <= 10'h3FF;
         pinPrev <= 6'h3F;
      end else if (ce) begin
         pinMeta <= {holdReleaseInputs_b, extIrqLineB_b, extIrqLineA_b, wakeIrqInputs_b};
         pinSync <= pinMeta;
         pinPrev <= pinSync[5:0];
      end
   end

   assign pinFall = pinPrev & ~pinSync[5:0];

   // ---------------------------------------------
   // Pending requests and priority selection
   // ---------------------------------------------
   logic [3:0]  wakePend;
   logic [7:0]  srcPend;
   logic [7:0]  irqMask;
   logic [7:0]  pendVec;
   logic [7:0]  reqVec;
   logic [2:0]  takeIdx;
   logic        takeInt;
   logic        cmdOk;
   psq_pkg::psq_state_e state;

   assign reqVec = {timer1Irq, pinFall[5], serialIrq, div1Irq, pinFall[4], 1'b0, timer0Irq, div0Irq};
   assign pendVec = {srcPend[7:3], |wakePend, srcPend[1:0]} & irqMask;
   assign cmdOk = (state == psq_pkg::ST_IDLE);
   assign takeInt = cmdOk && intEnable && (|pendVec)
                    && (cmd.op == psq_pkg::CMD_NONE || cmd.op == psq_pkg::CMD_STEP);

   always_comb begin
      takeIdx = 3'd7;
      for (int i = `PSQ_NUM_IRQ - 1; i >= 0; i--) begin
         if (pendVec[i]) begin
            takeIdx = 3'(i);
         end
      end
   end

   // A request arriving while its bit is cleared survives the clear.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         srcPend <= '0;
      end else if (ce) begin
         for (int i = 0; i < `PSQ_NUM_IRQ; i++) begin
            if (reqVec[i]) begin
               srcPend[i] <= 1'b1;
            end else if (takeInt && takeIdx == 3'(i)) begin
               srcPend[i] <= 1'b0;
            end
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gWake
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               wakePend[g] <= 1'b0;
            end else if (ce) begin
               if (pinFall[g]) begin
                  wakePend[g] <= 1'b1;
               end else if (takeInt && takeIdx == 3'(`PSQ_IRQ_WAKE)) begin
                  wakePend[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Hold release never touches the pending bits.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         holdRelease <= 1'b0;
      end else if (ce) begin
         holdRelease <= holdActive && !(&pinSync[9:6]);
      end
   end

   // ---------------------------------------------
   // Return stack
   // ---------------------------------------------
   logic [3:0]        sp;
   logic              push;
   psq_pkg::psq_ctx_s pushData;
   psq_pkg::psq_ctx_s popData;
   logic [6:0]        popMask;
   logic [14:0]       pcNext1;

   assign pcNext1 = pc + 15'd1;
   assign push = takeInt || (cmdOk && cmd.op == psq_pkg::CMD_CALL);
   assign pushData = '{pc: takeInt ? pc : pcNext1, regs: regs, acc: accIn, carry: carryIn};

   psq_stack_mem uStack (
      .clk    (clk),
      .rst_b  (rst_b),
      .ce     (ce),
      .wrEn   (push),
      .wrAddr (sp),
      .wrData (pushData),
      .rdAddr (sp - 4'd1),
      .rdData (popData)
   );

   // The pointer wraps modulo sixteen, so the oldest level is overwritten.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sp <= '0;
      end else if (ce) begin
         if (push) begin
            sp <= sp + 4'd1;
         end else if (cmdOk && (cmd.op == psq_pkg::CMD_RET || cmd.op == psq_pkg::CMD_RETM)) begin
            sp <= sp - 4'd1;
         end
      end
   end

   // ---------------------------------------------
   // Sequencing state and program counter
   // ---------------------------------------------
   logic [14:0] tableWord;

   assign tableWord = `PSQ_TABLE_BASE + {1'b0, regs.tab[15:2]};

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state   <= psq_pkg::ST_IDLE;
         popMask <= '0;
      end else if (ce) begin
         unique case (state)
            psq_pkg::ST_IDLE: begin
               if (!takeInt && cmd.op == psq_pkg::CMD_RET) begin
                  state   <= psq_pkg::ST_POP;
                  popMask <= '0;
               end else if (!takeInt && cmd.op == psq_pkg::CMD_RETM) begin
                  state   <= psq_pkg::ST_POP;
                  popMask <= cmd.mask;
               end else if (!takeInt && cmd.op == psq_pkg::CMD_TABLE) begin
                  state <= psq_pkg::ST_TABLE;
               end
            end
            psq_pkg::ST_POP: state <= psq_pkg::ST_IDLE;
            psq_pkg::ST_TABLE: state <= psq_pkg::ST_IDLE;
            default: state <= psq_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pc <= `PSQ_PC_RESET;
      end else if (ce) begin
         if (takeInt) begin
            pc <= `PSQ_VEC_FIRST + {10'd0, takeIdx, 2'b00};
         end else if (state == psq_pkg::ST_POP) begin
            pc <= popData.pc;
         end else if (cmdOk) begin
            unique case (cmd.op)
               psq_pkg::CMD_STEP: pc <= pcNext1;
               psq_pkg::CMD_JUMP, psq_pkg::CMD_CALL: pc <= {regs.codePage, cmd.target};
               psq_pkg::CMD_BRANCH: pc <= {pc[14:`PSQ_PAGE_LSB], cmd.target};
               default: pc <= pc;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         romAddr     <= `PSQ_PC_RESET;
         busy        <= 1'b0;
         intTaken    <= 1'b0;
         tableNibble <= '0;
         tableValid  <= 1'b0;
      end else if (ce) begin
         busy       <= (state == psq_pkg::ST_IDLE) && !takeInt && (cmd.op == psq_pkg::CMD_RET
                       || cmd.op == psq_pkg::CMD_RETM || cmd.op == psq_pkg::CMD_TABLE);
         intTaken   <= takeInt;
         tableValid <= (state == psq_pkg::ST_TABLE);
         if (cmdOk && !takeInt && cmd.op == psq_pkg::CMD_TABLE) begin
            romAddr <= tableWord;
         end else begin
            romAddr <= pc;
         end
         if (state == psq_pkg::ST_TABLE) begin
            tableNibble <= romData[{regs.tab[1:0], 2'b00} +: 4];
         end
      end
   end

   // ---------------------------------------------
   // Context registers and accumulator restore
   // ---------------------------------------------
   logic restoring;
   assign restoring = (state == psq_pkg::ST_POP);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         regs      <= '0;
         accOut    <= '0;
         accLoad   <= 1'b0;
         carryOut  <= 1'b0;
         carryLoad <= 1'b0;
      end else if (ce) begin
         accLoad   <= restoring && popMask[`PSQ_MASK_ACC];
         carryLoad <= restoring && popMask[`PSQ_MASK_CARRY];
         accOut    <= popData.acc;
         carryOut  <= popData.carry;
         if (restoring) begin
            if (popMask[`PSQ_MASK_TAB]) regs.tab <= popData.regs.tab;
            if (popMask[`PSQ_MASK_BANK]) begin
               regs.dbkLow  <= popData.regs.dbkLow;
               regs.dbkHigh <= popData.regs.dbkHigh;
            end
            if (popMask[`PSQ_MASK_WRP]) regs.work_reg_page <= popData.regs.work_reg_page;
            if (popMask[`PSQ_MASK_ROMPG]) regs.codePage <= popData.regs.codePage;
            if (popMask[`PSQ_MASK_RAMPG]) regs.ramPage <= popData.regs.ramPage;
         end
         if (regWr) begin
            unique case (regAddr)
               `PSQ_ADDR_PAGE:  regs.codePage <= regWrData[3:0];
               `PSQ_ADDR_TABLE_POINTER_NIBBLE_0:  regs.tab[3:0] <= regWrData[3:0];
               `PSQ_ADDR_TABLE_POINTER_NIBBLE_1:  regs.tab[7:4] <= regWrData[3:0];
               `PSQ_ADDR_TABLE_POINTER_NIBBLE_2:  regs.tab[11:8] <= regWrData[3:0];
               `PSQ_ADDR_TABLE_POINTER_NIBBLE_3:  regs.tab[15:12] <= regWrData[3:0];
               `PSQ_ADDR_DBKLO: regs.dbkLow <= regWrData[3:0];
               `PSQ_ADDR_DBKHI: regs.dbkHigh <= regWrData[1:0];
               `PSQ_ADDR_WRP:   regs.work_reg_page <= regWrData[3:0];
               `PSQ_ADDR_RAMPG: regs.ramPage <= regWrData[2:0];
               default: ;
            endcase
         end
      end
   end

   // ---------------------------------------------
   // Register read port
   // ---------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irqMask   <= `PSQ_IRQEN_RESET;
         regRdData <= '0;
      end else if (ce) begin
         if (regWr && regAddr == `PSQ_ADDR_IRQEN) irqMask <= regWrData[7:0];
         regRdData <= '0;
         if (regRd) begin
            unique case (regAddr)
               `PSQ_ADDR_PAGE:  regRdData <= {12'h0, regs.codePage};
               `PSQ_ADDR_TABLE_POINTER_NIBBLE_0:  regRdData <= {12'h0, regs.tab[3:0]};
               `PSQ_ADDR_TABLE_POINTER_NIBBLE_1:  regRdData <= {12'h0, regs.tab[7:4]};
               `PSQ_ADDR_TABLE_POINTER_NIBBLE_2:  regRdData <= {12'h0, regs.tab[11:8]};
               `PSQ_ADDR_TABLE_POINTER_NIBBLE_3:  regRdData <= {12'h0, regs.tab[15:12]};
               `PSQ_ADDR_DBKLO: regRdData <= {12'h0, regs.dbkLow};
               `PSQ_ADDR_DBKHI: regRdData <= {14'h0, regs.dbkHigh};
               `PSQ_ADDR_WRP:   regRdData <= {12'h0, regs.work_reg_page};
               `PSQ_ADDR_RAMPG: regRdData <= {13'h0, regs.ramPage};
               `PSQ_ADDR_PEND:  regRdData <= {4'h0, wakePend, srcPend[7:3], 1'b0, srcPend[1:0]};
               `PSQ_ADDR_SP:    regRdData <= {12'h0, sp};
               `PSQ_ADDR_IRQEN: regRdData <= {8'h0, irqMask};
               `PSQ_ADDR_PC:    regRdData <= {1'b0, pc};
               default:         regRdData <= '0;
            endcase
         end
      end
   end

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   logic idleCmd;
   assign idleCmd = ce && cmdOk && !takeInt;

   AST_STEP_ADDS_ONE: assert property (idleCmd && cmd.op == psq_pkg::CMD_STEP |=> pc == $past(pc) + 15'd1)
      else $error("Sequential fetch did not advance by one.");
   AST_FAR_TARGET: assert property (idleCmd && cmd.op == psq_pkg::CMD_JUMP |=> pc[14:11] == $past(regs.codePage))
      else $error("Far jump did not use the page bits.");
   AST_NEAR_PAGE: assert property (idleCmd && cmd.op == psq_pkg::CMD_BRANCH |=> pc[14:11] == $past(pc[14:11]))
      else $error("Branch left the current page.");
   AST_VECTOR: assert property (ce && takeInt |=> intTaken && pc == `PSQ_VEC_FIRST + {10'd0, $past(takeIdx), 2'b00})
      else $error("Interrupt vector address wrong.");
   AST_PRIORITY: assert property (ce && takeInt && pendVec[0] |=> pc == `PSQ_VEC_FIRST)
      else $error("Highest priority request not served first.");
   AST_SP_WRAP: assert property (ce && push && sp == 4'hF |=> sp == 4'h0)
      else $error("Stack pointer did not wrap.");
   AST_CALL_RETURN: assert property (idleCmd && cmd.op == psq_pkg::CMD_CALL ##1 ce && cmdOk && !takeInt
                                     && cmd.op == psq_pkg::CMD_RET |=> ##1 pc == $past(pc, 3) + 15'd1)
      else $error("Return did not restore the pushed counter.");
   AST_PLAIN_KEEPS: assert property (ce && restoring && popMask == 7'h00 && !regWr |=> regs == $past(regs))
      else $error("Plain return changed saved context.");
   AST_MASK_PAGE: assert property (ce && restoring && popMask[3] && !regWr |=> regs.codePage == $past(popData.regs.codePage))
      else $error("Masked return did not restore the page.");
   AST_TABLE_ADDR: assert property (idleCmd && cmd.op == psq_pkg::CMD_TABLE |=> romAddr == $past(tableWord) ##1 tableValid)
      else $error("Table read address or strobe wrong.");
   AST_HOLD_QUIET: assert property (ce && !holdActive |=> !holdRelease)
      else $error("Hold release outside hold.");

   COV_INT: cover property (ce && takeInt);
   COV_RETM: cover property (ce && restoring && popMask == 7'h7F);
   COV_TABLE: cover property (tableValid);
   COV_WRAP: cover property (ce && push && sp == 4'hF);
endmodule
`default_nettype wire

//--- rtl/psq_stack_mem.sv
// Sixteen-entry return stack storage with registered read data.
`default_nettype none
`include "psq_defs.svh"
module psq_stack_mem (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              ce,
   input  wire logic              wrEn,
   input  wire logic [3:0]        wrAddr,
   input  wire psq_pkg::psq_ctx_s wrData,
   input  wire logic [3:0]        rdAddr,
   output var  psq_pkg::psq_ctx_s rdData
);
   psq_pkg::psq_ctx_s mem [`PSQ_STACK_DEPTH];

   always_ff @(posedge clk) begin
      if (ce && wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdData <= '0;
      end else if (ce) begin
         rdData <= mem[rdAddr];
      end
   end
endmodule
`default_nettype wire

//--- tb/program_sequencer_stack_test.sv
// Self-checking bench for the program sequencer and return stack.
`default_nettype none
module program_sequencer_stack_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic               clk;
   logic               rst_b;
   logic               ce;
   logic [3:0]         regAddr;
   logic [15:0]        regWrData;
   logic               regWr;
   logic               regRd;
   logic [15:0]        regRdData;
   psq_pkg::psq_cmd_s  cmd;
   logic [3:0]         accIn;
   logic               carryIn;
   logic               intEnable;
   logic [7:0]         irqSel;
   logic [3:0]         wakeIrqInputs_b;
   logic               extIrqLineA_b;
   logic               extIrqLineB_b;
   logic [3:0]         holdReleaseInputs_b;
   logic               holdActive;
   logic [15:0]        romData;
   logic [14:0]        pc;
   logic [14:0]        romAddr;
   logic               busy;
   psq_pkg::psq_regs_s regs;
   logic [3:0]         accOut;
   logic               accLoad;
   logic               carryOut;
   logic               carryLoad;
   logic [3:0]         tableNibble;
   logic               tableValid;
   logic               intTaken;
   logic               holdRelease;
   int                 failCount;
   int                 samplesChecked;
   logic [31:0]        seed = 32'hee44_a936;

   psq_sequencer uut (.clk(clk), .rst_b(rst_b), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .cmd(cmd), .accIn(accIn), .carryIn(carryIn),
      .intEnable(intEnable), .div0Irq(irqSel[0]), .timer0Irq(irqSel[1]), .div1Irq(irqSel[4]),
      .serialIrq(irqSel[5]), .timer1Irq(irqSel[7]), .wakeIrqInputs_b(wakeIrqInputs_b),
      .extIrqLineA_b(extIrqLineA_b), .extIrqLineB_b(extIrqLineB_b), .holdReleaseInputs_b(holdReleaseInputs_b),
      .holdActive(holdActive), .romData(romData), .pc(pc), .romAddr(romAddr), .busy(busy), .regs(regs),
      .accOut(accOut), .accLoad(accLoad), .carryOut(carryOut), .carryLoad(carryLoad),
      .tableNibble(tableNibble), .tableValid(tableValid), .intTaken(intTaken), .holdRelease(holdRelease));
   psq_rom_model rom (.romAddr(romAddr), .romData(romData));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [3:0] romNib(input logic [15:0] t);
      logic [15:0] w;
      w = {15'h4000 + 15'(t[15:2]), 1'b0} ^ 16'hA5C3;
      return w[4 * t[1:0] +: 4];
   endfunction
   task automatic chk(input bit ok, input string msg);
      samplesChecked++;
      if (!ok) begin
         failCount++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      d = regRdData;
   endtask
   task automatic op(input psq_pkg::psq_cmd_e o, input logic [10:0] t, input logic [6:0] m);
      @(posedge clk);
      cmd <= '{op: o, target: t, mask: m};
      @(posedge clk);
      cmd <= '{op: psq_pkg::CMD_NONE, target: 11'h000, mask: 7'h00};
      #1;
   endtask
   task automatic waitInt(input logic [14:0] v, input string msg);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      while (intTaken !== 1'b1 && n < 10) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(intTaken === 1'b1 && pc === v, msg);
   endtask
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      failCount++;
      complete_run();
   end
   initial begin
      logic [15:0] d;
      logic [15:0] tb;
      logic [14:0] ret;
      logic [3:0]  p1;
      logic [3:0]  w1;
      logic [3:0]  a1;
      logic [10:0] t;
      logic [6:0]  m;
      rst_b = 1'b0;
      ce = 1'b1;
      regAddr = 4'h0;
      regWrData = 16'h0000;
      regWr = 1'b0;
      regRd = 1'b0;
      cmd = '0;
      accIn = 4'h0;
      carryIn = 1'b0;
      intEnable = 1'b0;
      irqSel = 8'h00;
      wakeIrqInputs_b = 4'hF;
      extIrqLineA_b = 1'b1;
      extIrqLineB_b = 1'b1;
      holdReleaseInputs_b = 4'hF;
      holdActive = 1'b0;
      failCount = 0;
      samplesChecked = 0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      #1;
      chk(pc === 15'h0000, "pc after reset");
      rd(4'hD, d);
      chk(d === 16'h0000, "unmapped read");
      for (int i = 0; i < 3; i++) begin
         ret = pc + 15'd1;
         op(psq_pkg::CMD_STEP, 11'h000, 7'h00);
         chk(pc === ret, "step");
      end
      // Every page value, then an in-page branch after the page register moved.
      for (int p = 0; p < 16; p++) begin
         t = 11'(rnd());
         wr(4'h0, 16'(p));
         rd(4'h0, d);
         chk(d === {12'h000, 4'(p)}, "page readback");
         op(psq_pkg::CMD_JUMP, t, 7'h00);
         chk(pc === {4'(p), t}, "far jump");
         t = 11'(rnd());
         wr(4'h0, {12'h000, 4'(p) ^ 4'h5});
         op(psq_pkg::CMD_BRANCH, t, 7'h00);
         chk(pc === {4'(p), t}, "branch page");
      end
      wr(4'h0, 16'h000F);
      op(psq_pkg::CMD_JUMP, 11'h7FF, 7'h00);
      op(psq_pkg::CMD_STEP, 11'h000, 7'h00);
      chk(pc === 15'h0000, "counter wrap");
      for (int i = 0; i < 6; i++) begin
         p1 = 4'(rnd());
         w1 = 4'(rnd());
         a1 = 4'(rnd());
         t = 11'(rnd());
         m = (i == 0) ? 7'h00 : ((i == 5) ? 7'h7F : 7'(rnd()));
         wr(4'h0, {12'h000, p1});
         wr(4'h7, {12'h000, w1});
         accIn <= a1;
         carryIn <= a1[0];
         ret = pc + 15'd1;
         op(psq_pkg::CMD_CALL, t, 7'h00);
         chk(pc === {p1, t}, "call target");
         wr(4'h0, {12'h000, ~p1});
         wr(4'h7, {12'h000, ~w1});
         op((i == 0) ? psq_pkg::CMD_RET : psq_pkg::CMD_RETM, 11'h000, m);
         chk(busy === 1'b1, "return busy");
         @(posedge clk);
         #1;
         chk(pc === ret, "return pc");
         chk(regs.codePage === (m[3] ? p1 : ~p1) && regs.work_reg_page === (m[2] ? w1 : ~w1), "restore");
         chk(accLoad === m[5] && carryLoad === m[6] && (!m[5] || accOut === a1)
             && (!m[6] || carryOut === a1[0]), "acc restore");
      end
      // Seventeen calls overwrite the oldest level; the seventeenth return sees it.
      wr(4'h0, 16'h0003);
      rd(4'hA, d);
      a1 = d[3:0];
      for (int i = 0; i < 17; i++) op(psq_pkg::CMD_CALL, 11'(i), 7'h00);
      rd(4'hA, d);
      chk(d[3:0] === a1 + 4'd1, "stack depth");
      for (int i = 0; i < 17; i++) begin
         op(psq_pkg::CMD_RET, 11'h000, 7'h00);
         @(posedge clk);
         #1;
         chk(pc === {4'h3, (i == 16) ? 11'd16 : 11'(16 - i)}, "lifo order");
      end
      // Return in the cycle right after a call, then a step while the clock enable is low.
      ret = pc + 15'd1;
      @(posedge clk);
      cmd <= '{op: psq_pkg::CMD_CALL, target: 11'(rnd()), mask: 7'h00};
      @(posedge clk);
      cmd <= '{op: psq_pkg::CMD_RET, target: 11'h000, mask: 7'h00};
      @(posedge clk);
      cmd <= '{op: psq_pkg::CMD_NONE, target: 11'h000, mask: 7'h00};
      @(posedge clk);
      #1;
      chk(pc === ret, "call then return");
      ret = pc;
      ce <= 1'b0;
      op(psq_pkg::CMD_STEP, 11'h000, 7'h00);
      ce <= 1'b1;
      chk(pc === ret, "frozen step");
      for (int i = 0; i < 4; i++) begin
         tb = (i == 0) ? 16'hFFFF : 16'(rnd());
         for (int k = 0; k < 4; k++) wr(4'(k + 1), {12'h000, tb[4 * k +: 4]});
         op(psq_pkg::CMD_TABLE, 11'h000, 7'h00);
         chk(busy === 1'b1 && romAddr === 15'h4000 + 15'(tb[15:2]), "table address");
         @(posedge clk);
         #1;
         chk(tableValid === 1'b1 && tableNibble === romNib(tb), "table nibble");
      end
      @(posedge clk);
      irqSel <= 8'hA1;
      @(posedge clk);
      irqSel <= 8'h00;
      @(posedge clk);
      intEnable <= 1'b1;
      waitInt(15'h0004, "priority 1");
      waitInt(15'h0018, "priority 2");
      waitInt(15'h0020, "priority 3");
      for (int s = 0; s < 8; s++) begin
         if (s == 2 || s == 3 || s == 6) continue;
         @(posedge clk);
         irqSel <= 8'(1 << s);
         @(posedge clk);
         irqSel <= 8'h00;
         waitInt(15'h0004 + 15'(4 * s), "source vector");
      end
      for (int w = 0; w < 6; w++) begin
         @(posedge clk);
         if (w < 4) wakeIrqInputs_b[w] <= 1'b0;
         else if (w == 4) extIrqLineA_b <= 1'b0;
         else extIrqLineB_b <= 1'b0;
         waitInt(w < 4 ? 15'h000C : (w == 4 ? 15'h0010 : 15'h001C), "pin vector");
         @(posedge clk);
         wakeIrqInputs_b <= 4'hF;
         extIrqLineA_b <= 1'b1;
         extIrqLineB_b <= 1'b1;
         repeat (4) @(posedge clk);
      end
      holdActive <= 1'b1;
      a1 = 4'(rnd());
      holdReleaseInputs_b[a1[1:0]] <= 1'b0;
      ret = pc;
      repeat (4) @(posedge clk);
      #1;
      chk(holdRelease === 1'b1 && pc === ret && intTaken === 1'b0, "hold release");
      complete_run();
   end
endmodule
`default_nettype wire

//--- tb/psq_rom_model.sv
// Program memory model that answers the sequencer's fetch address.
`default_nettype none
module psq_rom_model (
   input  wire logic [14:0] romAddr,
   output var  logic [15:0] romData
);
   timeunit 1ns;
   timeprecision 1ns;
   // Each word scrambles its own address, so no two words hold the same data.
   assign romData = {romAddr, 1'b0} ^ 16'hA5C3;
endmodule
`default_nettype wire
